// File: design/rxlp_extreme_track.sv
/*
   min and max tracker of the instantaneous demodulated frequency.
   assumes samples arrive as one-cycle strobes and the estimate comes from the caller.
*/
`timescale 1ns/10ps
`default_nettype none
module rxlp_extreme_track
   import rxlp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clear,
   input wire logic sampleValid,
   input wire logic signed [FREQ_W-1:0] sample,
   input wire logic signed [FREQ_W-1:0] estimate,
   output logic signed [FREQ_W-1:0] midPoint
);
   logic signed [FREQ_W-1:0] maxR_r, maxR_nxt, minR_r, minR_nxt;
   logic signed [FREQ_W:0] sum;

   // extremes leak toward the estimate so a stale peak cannot pin the offset forever
   always_comb begin
      maxR_nxt = maxR_r;
      minR_nxt = minR_r;
      if (clear) begin
         // only a real sample may seed the extremes; the bus carries junk between strobes
         if (sampleValid) begin
            maxR_nxt = sample;
            minR_nxt = sample;
         end
      end else if (sampleValid) begin
         maxR_nxt = (sample > maxR_r) ? sample :
            FREQ_W'(maxR_r - ((maxR_r - estimate) >>> TRACK_DECAY_SHIFT));
         minR_nxt = (sample < minR_r) ? sample :
            FREQ_W'(minR_r + ((estimate - minR_r) >>> TRACK_DECAY_SHIFT));
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         maxR_r <= '0;
         minR_r <= '0;
      end else begin
         maxR_r <= maxR_nxt;
         minR_r <= minR_nxt;
      end
   end

   // the dc offset is the centre between the two extremes
   assign sum = (FREQ_W+1)'(maxR_r) + (FREQ_W+1)'(minR_r);
   assign midPoint = FREQ_W'(sum >>> 1);
endmodule
`default_nettype wire

// File: design/rxlp_loops.sv
/*
   receiver frequency compensation and gain control loops.
   assumes sample strobes, rssi, sync and peak level are synchronous to sys_clk;
   configuration is held stable by the host while the loops run.
*/
`timescale 1ns/10ps
`default_nettype none
module rxlp_loops
   import rxlp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic modIsFreq,
   input wire logic [7:0] rssiLevel,
   input wire logic syncDetected,
   input wire logic sampleValid,
   input wire logic signed [FREQ_W-1:0] sampleFreq,
   input wire rxlp_afc_cfg_t afcCfg,
   input wire rxlp_agc_cfg_t agcCfg,
   input wire logic [3:0] peakAmp,
   output logic signed [FREQ_W-1:0] freqErrorEstimate,
   output logic signed [FREQ_W-1:0] slicerOffset,
   output logic signed [FREQ_W-1:0] ifCorrection,
   output logic afcFastMode,
   output logic [3:0] attenStep,
   output logic agcInRange
);
   // frequency loop state
   rxlp_afc_st_t afcSt_r, afcSt_nxt;
   logic [7:0] fastCnt_r, fastCnt_nxt;
   logic signed [FREQ_W-1:0] est_r, est_nxt;
   logic signed [FREQ_W-1:0] slicer_r, slicer_nxt, ifCorr_r, ifCorr_nxt;
   logic signed [FREQ_W-1:0] midPoint;
   logic signed [FREQ_W:0] diff;
   logic [3:0] gainLog2;
   logic afcRun, afcGo, trackClear;

   // loop may run only with its enable set and a frequency modulation selected
   assign afcRun = afcCfg.enable & modIsFreq;
   assign afcGo = afcRun & (rssiLevel > afcCfg.powerThr);
   assign trackClear = (afcSt_r == AFC_IDLE);
   assign gainLog2 = (afcSt_r == AFC_FAST) ? afcCfg.fastGainLog2 : afcCfg.slowGainLog2;

   rxlp_extreme_track u_track (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .clear(trackClear),
      .sampleValid(sampleValid),
      .sample(sampleFreq),
      .estimate(est_r),
      .midPoint(midPoint)
   );

   // mode sequencing: fast after power threshold, slow after period, or after sync when the period is zero
   always_comb begin
      afcSt_nxt = afcSt_r;
      fastCnt_nxt = fastCnt_r;
      case (afcSt_r)
         AFC_IDLE: begin
            fastCnt_nxt = '0;
            if (afcGo) begin
               afcSt_nxt = AFC_FAST;
            end
         end
         AFC_FAST: begin
            if (!afcRun) begin
               afcSt_nxt = AFC_IDLE;
            end else if (afcCfg.fastPeriod == 8'h00) begin
               if (syncDetected) begin
                  afcSt_nxt = AFC_SLOW;
               end
            end else if (sampleValid) begin
               fastCnt_nxt = 8'(fastCnt_r + 8'h01);
               if (fastCnt_nxt == afcCfg.fastPeriod) begin
                  afcSt_nxt = AFC_SLOW;
               end
            end
         end
         AFC_SLOW: begin
            if (!afcRun) begin
               afcSt_nxt = AFC_IDLE;
            end
         end
         default: begin
            afcSt_nxt = AFC_IDLE;
         end
      endcase
   end

   // estimate moves toward the extremes' midpoint by 2^-gain per sample;
   // the step never overshoots the midpoint, so the sum cannot overflow
   assign diff = (FREQ_W+1)'(midPoint) - (FREQ_W+1)'(est_r);
   always_comb begin
      est_nxt = est_r;
      if (afcSt_r != AFC_IDLE && sampleValid && afcRun) begin
         est_nxt = FREQ_W'((FREQ_W+1)'(est_r) + (diff >>> gainLog2));
      end
      // only one destination carries the correction, none while disabled
      slicer_nxt = (afcRun && afcCfg.corrMode == CORR_SLICER) ? est_nxt : '0;
      ifCorr_nxt = (afcRun && afcCfg.corrMode == CORR_IF) ? est_nxt : '0;
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         afcSt_r <= AFC_IDLE;
         fastCnt_r <= '0;
         est_r <= '0;
         slicer_r <= '0;
         ifCorr_r <= '0;
      end else begin
         afcSt_r <= afcSt_nxt;
         fastCnt_r <= fastCnt_nxt;
         est_r <= est_nxt;
         slicer_r <= slicer_nxt;
         ifCorr_r <= ifCorr_nxt;
      end
   end

   assign freqErrorEstimate = est_r;
   assign slicerOffset = slicer_r;
   assign ifCorrection = ifCorr_r;
   assign afcFastMode = (afcSt_r == AFC_FAST);

   // gain loop state
   rxlp_agc_st_t agcSt_r, agcSt_nxt;
   logic [CNT_W-1:0] agcCnt_r, agcCnt_nxt, measLen, holdLen;
   logic [3:0] step_r, step_nxt, lowThr;
   logic inRange_r, inRange_nxt, frozen, lowSel, tooHigh, tooLow;

   // per-step low threshold; from step 0 no decrease is possible anyway
   assign lowSel = agcCfg.lowThrSel[3'(step_r - 4'h1)];
   assign lowThr = lowSel ? agcCfg.lowThr1 : agcCfg.lowThr0;
   assign tooHigh = (peakAmp > agcCfg.highThr);
   assign tooLow = (peakAmp < lowThr);
   assign frozen = agcCfg.freezeOnSync & syncDetected;
   // measure length doubles per field step; hold is linear in its field
   assign measLen = CNT_W'(AGC_TICK_CYC) << agcCfg.measTime;
   assign holdLen = CNT_W'(AGC_TICK_CYC) * CNT_W'(agcCfg.holdTime);

   // hold, then measure; raise at once, lower only after a full quiet interval
   always_comb begin
      agcSt_nxt = agcSt_r;
      agcCnt_nxt = agcCnt_r;
      step_nxt = step_r;
      inRange_nxt = !tooHigh && !tooLow;
      case (agcSt_r)
         AGC_OFF: begin
            agcCnt_nxt = '0;
            if (agcCfg.enable) begin
               agcSt_nxt = AGC_MEAS;
            end
         end
         AGC_HOLD: begin
            if (agcCnt_r >= holdLen) begin
               agcSt_nxt = AGC_MEAS;
               agcCnt_nxt = '0;
            end else begin
               agcCnt_nxt = CNT_W'(agcCnt_r + 1'b1);
            end
         end
         AGC_MEAS: begin
            agcCnt_nxt = '0;
            if (frozen) begin
               step_nxt = step_r;
            end else if (tooHigh) begin
               if (step_r < ATTEN_MAX_STEP) begin
                  step_nxt = step_r + 4'h1;
                  agcSt_nxt = AGC_HOLD;
               end
            end else if (tooLow && step_r != 4'h0) begin
               if (agcCnt_r == measLen - 1'b1) begin
                  step_nxt = step_r - 4'h1;
                  agcSt_nxt = AGC_HOLD;
               end else begin
                  agcCnt_nxt = CNT_W'(agcCnt_r + 1'b1);
               end
            end
         end
         default: begin
            agcSt_nxt = AGC_OFF;
         end
      endcase
      // disabling stops the loop but keeps the last attenuation
      if (!agcCfg.enable) begin
         agcSt_nxt = AGC_OFF;
         step_nxt = step_r;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         agcSt_r <= AGC_OFF;
         agcCnt_r <= '0;
         step_r <= '0;
         inRange_r <= 1'b0;
      end else begin
         agcSt_r <= agcSt_nxt;
         agcCnt_r <= agcCnt_nxt;
         step_r <= step_nxt;
         inRange_r <= inRange_nxt;
      end
   end

   assign attenStep = step_r;
   assign agcInRange = inRange_r;

   // checks on the frequency loop
   property p_amIdle;
      @(posedge sys_clk) disable iff (sys_rst)
      !modIsFreq |=> (afcSt_r == AFC_IDLE) && (slicerOffset == 0) && (ifCorrection == 0);
   endproperty
   a_amIdle: assert property (p_amIdle) else $error("frequency loop active under amplitude modulation");

   property p_offWhenDisabled;
      @(posedge sys_clk) disable iff (sys_rst)
      !afcCfg.enable |=> (slicerOffset == 0) && (ifCorrection == 0);
   endproperty
   a_offWhenDisabled: assert property (p_offWhenDisabled) else $error("correction applied while disabled");

   property p_routeIf;
      @(posedge sys_clk) disable iff (sys_rst)
      afcRun && afcCfg.corrMode |=> (slicerOffset == 0) && (ifCorrection == freqErrorEstimate);
   endproperty
   a_routeIf: assert property (p_routeIf) else $error("second IF correction misrouted");

   property p_startFast;
      @(posedge sys_clk) disable iff (sys_rst)
      (afcSt_r == AFC_IDLE) && afcGo |=> afcFastMode;
   endproperty
   a_startFast: assert property (p_startFast) else $error("fast mode not entered above threshold");

   property p_syncSlow;
      @(posedge sys_clk) disable iff (sys_rst)
      afcFastMode && afcRun && (afcCfg.fastPeriod == 8'h00) && syncDetected |=> (afcSt_r == AFC_SLOW);
   endproperty
   a_syncSlow: assert property (p_syncSlow) else $error("zero fast period did not switch on sync");

   property p_estOnSample;
      @(posedge sys_clk) disable iff (sys_rst)
      !sampleValid |=> $stable(freqErrorEstimate);
   endproperty
   a_estOnSample: assert property (p_estOnSample) else $error("estimate moved without a sample");

   // with a zero log2 gain in fast mode the estimate lands on the midpoint in one sample
   property p_fastGainUsed;
      @(posedge sys_clk) disable iff (sys_rst)
      afcFastMode && afcRun && sampleValid && (afcCfg.fastGainLog2 == 4'h0)
         |=> (freqErrorEstimate == $past(midPoint));
   endproperty
   a_fastGainUsed: assert property (p_fastGainUsed) else $error("fast gain not applied");

   property p_fastPeriodEnd;
      @(posedge sys_clk) disable iff (sys_rst)
      afcFastMode && afcRun && sampleValid && (afcCfg.fastPeriod != 8'h00)
         && (8'(fastCnt_r + 8'h01) == afcCfg.fastPeriod) |=> (afcSt_r == AFC_SLOW);
   endproperty
   a_fastPeriodEnd: assert property (p_fastPeriodEnd) else $error("fast period did not end on its last sample");

   // checks on the gain loop
   property p_stepLimit;
      @(posedge sys_clk) disable iff (sys_rst)
      attenStep <= ATTEN_MAX_STEP;
   endproperty
   a_stepLimit: assert property (p_stepLimit) else $error("attenuation step beyond top");

   property p_raise;
      @(posedge sys_clk) disable iff (sys_rst)
      (agcSt_r == AGC_MEAS) && agcCfg.enable && !frozen && tooHigh && (step_r < ATTEN_MAX_STEP)
         |=> (attenStep == $past(attenStep) + 4'h1) && (agcSt_r == AGC_HOLD);
   endproperty
   a_raise: assert property (p_raise) else $error("no increase above high threshold");

   property p_lowerCause;
      @(posedge sys_clk) disable iff (sys_rst)
      (attenStep < $past(attenStep)) |-> $past(tooLow) && ($past(agcCnt_r) == $past(measLen) - 1'b1);
   endproperty
   a_lowerCause: assert property (p_lowerCause) else $error("decrease without full quiet interval");

   property p_holdAfter;
      @(posedge sys_clk) disable iff (sys_rst)
      $changed(attenStep) |-> (agcSt_r == AGC_HOLD) ##1 $stable(attenStep);
   endproperty
   a_holdAfter: assert property (p_holdAfter) else $error("no hold after attenuation change");

   property p_freeze;
      @(posedge sys_clk) disable iff (sys_rst)
      frozen ##1 frozen |-> $stable(attenStep);
   endproperty
   a_freeze: assert property (p_freeze) else $error("attenuation moved after sync freeze");

   property p_enableGate;
      @(posedge sys_clk) disable iff (sys_rst)
      !agcCfg.enable |=> $stable(attenStep) && (agcSt_r == AGC_OFF);
   endproperty
   a_enableGate: assert property (p_enableGate) else $error("gain loop ran while disabled");

   // a hold may not be cut short while the loop stays enabled
   property p_holdFull;
      @(posedge sys_clk) disable iff (sys_rst)
      (agcSt_r == AGC_HOLD) && agcCfg.enable && (agcCnt_r < holdLen) |=> (agcSt_r == AGC_HOLD);
   endproperty
   a_holdFull: assert property (p_holdFull) else $error("hold interval ended early");

   // any level at or above the low threshold restarts the quiet interval
   property p_quietRestart;
      @(posedge sys_clk) disable iff (sys_rst)
      (agcSt_r == AGC_MEAS) && !tooLow |=> (agcCnt_r == '0);
   endproperty
   a_quietRestart: assert property (p_quietRestart) else $error("quiet interval not restarted");
endmodule
`default_nettype wire

// File: design/rxlp_pkg.sv
/*
   constants, states and config carriers for the receiver frequency and gain loops.
   assumes the digital clock of the loops is the 20 MHz system clock itself.
*/
// Function
// - frequency loop acts only under FSK or GFSK modulation, idle under amplitude modulation
// - track min and max demodulated frequency, correct the resulting DC offset
// - correction mode 0 offsets the slicer, mode 1 retunes the second IF
// - current estimated frequency error is readable for centre frequency trimming
// - start fast mode above the power threshold, go slow after the fast period
// - fast and slow gains are log2 values 0 to 15, current mode's gain used
// - fast period counts 0 to 255 samples; zero means fast until sync detection
// - frequency correction is applied only while the loop enable is set
// - gain loop steps attenuation by 6 dB up to 48 dB
// - peak amplitude after decimation is compared with a low and a high threshold
// - above high threshold, one increase per hold interval, no measure interval
// - decrease only after a full measure interval below the low threshold, then hold
// - high threshold is programmable 0 to 15; above it attenuation rises
// - two low thresholds, a per-step select field picks one
// - measure interval is 12 digital clocks times two to the measure field
// - after each change wait 12 digital clocks times the hold field
// - with freeze-on-sync set, attenuation stops changing after sync
// - gain loop repeats until level lies in range, runs only when enabled
package rxlp_pkg;
   localparam int SYS_CLK_HZ = 20000000;
   localparam int DIG_CLK_HZ = 20000000;
   // one gain-loop tick, in digital clock periods, and the same in sys_clk cycles
   localparam int AGC_TICK_PERIODS = 12;
   localparam int AGC_TICK_CYC = (AGC_TICK_PERIODS * SYS_CLK_HZ) / DIG_CLK_HZ;
   localparam int FREQ_W = 12;
   localparam int CNT_W = 19;
   localparam int TRACK_DECAY_SHIFT = 4;
   localparam int ATTEN_STEP_DB = 6;
   localparam int MAX_ATTEN_DB = 48;
   localparam logic [3:0] ATTEN_MAX_STEP = 4'(MAX_ATTEN_DB / ATTEN_STEP_DB);
   localparam logic CORR_SLICER = 1'b0;
   localparam logic CORR_IF = 1'b1;

   typedef enum logic [1:0] {
      AFC_IDLE = 2'b00,
      AFC_FAST = 2'b01,
      AFC_SLOW = 2'b10
   } rxlp_afc_st_t;

   typedef enum logic [1:0] {
      AGC_OFF = 2'b00,
      AGC_HOLD = 2'b01,
      AGC_MEAS = 2'b10
   } rxlp_agc_st_t;

   typedef struct packed {
      logic enable;
      logic corrMode;
      logic [3:0] fastGainLog2;
      logic [3:0] slowGainLog2;
      logic [7:0] fastPeriod;
      logic [7:0] powerThr;
   } rxlp_afc_cfg_t;

   typedef struct packed {
      logic enable;
      logic freezeOnSync;
      logic [3:0] highThr;
      logic [3:0] lowThr0;
      logic [3:0] lowThr1;
      logic [7:0] lowThrSel;
      logic [3:0] measTime;
      logic [5:0] holdTime;
   } rxlp_agc_cfg_t;
endpackage

// File: testbench/rxlp_partner.sv
/*
   front-end model: rf gain chain and demodulator sample path.
   assumes the attenuation step comes from the loops under test.
*/
`timescale 1ns/10ps
`default_nettype none
module rxlp_partner
   import rxlp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [3:0] attenStep,
   input wire logic [5:0] rfLevel,
   input wire logic sampleEn,
   input wire logic signed [FREQ_W-1:0] freqOffset,
   input wire logic signed [FREQ_W-1:0] freqDev,
   output logic [3:0] peakAmp,
   output logic sampleValid,
   output logic signed [FREQ_W-1:0] sampleFreq
);
   logic [1:0] gap_r, gap_nxt;
   logic phase_r, phase_nxt, valid_nxt;
   logic signed [FREQ_W-1:0] freq_nxt;
   int lvl;
   // one 6 dB step costs two peak counts; the detector clips at 4 bits
   always_comb begin
      lvl = int'(rfLevel) - 2 * int'(attenStep);
      peakAmp = (lvl < 0) ? 4'h0 : (lvl > 15) ? 4'hf : 4'(lvl);
   end
   // a sample every fourth cycle; between samples the bus toggles so stale data never looks valid
   always_comb begin
      gap_nxt = sampleEn ? gap_r + 2'h1 : 2'h0;
      valid_nxt = sampleEn && gap_r == 2'h3;
      phase_nxt = phase_r ^ valid_nxt;
      freq_nxt = ~sampleFreq;
      if (valid_nxt) begin
         freq_nxt = phase_r ? freqOffset + freqDev : freqOffset - freqDev;
      end
   end
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         gap_r <= 2'h0;
         phase_r <= 1'b0;
         sampleValid <= 1'b0;
         sampleFreq <= '0;
      end else begin
         gap_r <= gap_nxt;
         phase_r <= phase_nxt;
         sampleValid <= valid_nxt;
         sampleFreq <= freq_nxt;
      end
   end
endmodule
`default_nettype wire

// File: testbench/test_rx_afc_agc_loops.sv
/*
   self-checking bench for the receiver frequency and gain loops.
   assumes rxlp_pkg, rxlp_loops and rxlp_partner are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module test_rx_afc_agc_loops
   import rxlp_pkg::*;
;
   typedef struct {logic [3:0] val; int gap;} rxlp_note_t;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic modIsFreq, syncDetected, sampleEn, prevFast;
   logic [7:0] rssiLevel;
   logic [5:0] rfLevel;
   logic [3:0] prevAtt;
   logic signed [FREQ_W-1:0] freqOffset, freqDev, diff;
   rxlp_afc_cfg_t afcCfg;
   rxlp_agc_cfg_t agcCfg;
   wire logic sampleValid, afcFastMode, agcInRange;
   wire logic signed [FREQ_W-1:0] sampleFreq, freqErrorEstimate, slicerOffset, ifCorrection;
   wire logic [3:0] peakAmp, attenStep;
   int fail_count = 0;
   int checked = 0;
   int cyc = 0;
   int lastChg = 0;
   int n, k, m;
   integer seed = 32'ha454;
   rxlp_note_t attQ[$];
   logic fastQ[$];

   rxlp_loops u_rxlp_loops (.sys_clk(sys_clk), .sys_rst(sys_rst), .modIsFreq(modIsFreq),
      .rssiLevel(rssiLevel), .syncDetected(syncDetected), .sampleValid(sampleValid),
      .sampleFreq(sampleFreq), .afcCfg(afcCfg), .agcCfg(agcCfg), .peakAmp(peakAmp),
      .freqErrorEstimate(freqErrorEstimate), .slicerOffset(slicerOffset),
      .ifCorrection(ifCorrection), .afcFastMode(afcFastMode), .attenStep(attenStep),
      .agcInRange(agcInRange));
   rxlp_partner u_rxlp_partner (.sys_clk(sys_clk), .sys_rst(sys_rst), .attenStep(attenStep),
      .rfLevel(rfLevel), .sampleEn(sampleEn), .freqOffset(freqOffset), .freqDev(freqDev),
      .peakAmp(peakAmp), .sampleValid(sampleValid), .sampleFreq(sampleFreq));

   always #25 sys_clk = ~sys_clk;

   task automatic check(input string what, input logic signed [31:0] exp, input logic signed [31:0] got);
      checked++;
      if (got !== exp) begin
         $display("wrong value %s expected %0d seen %0d", what, exp, got);
         fail_count++;
      end
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic tick(input int c);
      repeat (c) @(posedge sys_clk);
      #1;
   endtask

   // a wait that runs out of its bound is a mismatch and ends the run
   task automatic expire(input string what);
      $display("wrong value %s expected done seen timeout", what);
      fail_count++;
      results();
   endtask

   // bounded wait until every note has been matched by the watcher
   task automatic drain(input int lim);
      int i;
      for (i = 0; i < lim && attQ.size() + fastQ.size() > 0; i++) @(posedge sys_clk);
      if (attQ.size() + fastQ.size() > 0) begin
         $display("wrong value pending notes expected 0 seen %0d", attQ.size() + fastQ.size());
         fail_count++;
         results();
      end
      tick(1);
   endtask

   // watcher: any change of a watched output takes the oldest note; a change with no note is a fault
   always begin
      @(posedge sys_clk);
      #2;
      cyc++;
      if (!sys_rst && attenStep !== prevAtt) begin
         if (attQ.size() == 0) begin
            check("attenStep hold", prevAtt, attenStep);
         end else begin
            check("attenStep", attQ[0].val, attenStep);
            if (attQ[0].gap > 0) check("step spacing", attQ[0].gap, cyc - lastChg);
            void'(attQ.pop_front());
         end
         lastChg = cyc;
      end
      if (!sys_rst && afcFastMode !== prevFast) begin
         check("afcFastMode", fastQ.size() ? fastQ[0] : prevFast, afcFastMode);
         if (fastQ.size() > 0) void'(fastQ.pop_front());
      end
      prevAtt = attenStep;
      prevFast = afcFastMode;
   end

   initial begin
      {modIsFreq, syncDetected, sampleEn, rssiLevel, rfLevel, freqOffset} = '0;
      freqDev = 12'h0c8;
      afcCfg = '0;
      agcCfg = '0;
      tick(4);
      sys_rst = 1'b0;
      tick(1);
      // gain rises one step per hold while clipped, then sticks at the top step
      rfLevel = 6'h28;
      for (k = 1; k <= 8; k++) attQ.push_back('{4'(k), (k == 1) ? 0 : AGC_TICK_CYC + 2});
      agcCfg = '{1'b1, 1'b0, 4'h5, 4'h3, 4'h9, 8'h30, 4'h0, 6'h01};
      drain(400);
      tick(60);
      check("agcInRange high", 0, agcInRange);
      $display("test gain increase done");
      // decrease after full quiet windows, threshold chosen per step
      agcCfg.enable = 1'b0;
      tick(2);
      m = $unsigned($random(seed)) % 3;
      agcCfg.measTime = 4'(m);
      rfLevel = 6'h0d; // step 5 sits on lowThr0, so only lowThr1 lets it fall to 4
      for (k = 7; k >= 4; k--) attQ.push_back('{4'(k), (k == 7) ? 0 : AGC_TICK_CYC + 1 + (AGC_TICK_CYC << m)});
      agcCfg.enable = 1'b1;
      drain(2000);
      tick((AGC_TICK_CYC << m) + 40);
      check("agcInRange", 1, agcInRange);
      $display("test gain decrease done");
      // frozen after sync, then disabled: no step may move
      agcCfg.freezeOnSync = 1'b1;
      syncDetected = 1'b1;
      tick(2);
      rfLevel = 6'h28;
      tick(100);
      agcCfg.enable = 1'b0;
      syncDetected = 1'b0;
      tick(100);
      rfLevel = 6'h0d;
      agcCfg.enable = 1'b1;
      tick(60);
      check("attenStep final", 4, attenStep);
      agcCfg.enable = 1'b0;
      $display("test gain freeze done");
      // frequency loop idle under amplitude modulation
      sampleEn = 1'b1;
      freqOffset = 12'($random(seed) % 400);
      afcCfg = '{1'b1, CORR_SLICER, 4'h0, 4'hf, 8'h08, 8'h64};
      rssiLevel = 8'h65;
      tick(40);
      check("fast under am", 0, afcFastMode);
      check("slicer under am", 0, slicerOffset);
      modIsFreq = 1'b1;
      rssiLevel = 8'h64;
      tick(20);
      fastQ.push_back(1'b1);
      fastQ.push_back(1'b0);
      rssiLevel = 8'h65;
      for (k = 0; k < 50 && afcFastMode !== 1'b1; k++) tick(1);
      if (afcFastMode !== 1'b1) expire("fast start");
      n = 0;
      for (k = 0; k < 400 && afcFastMode === 1'b1; k++) begin
         if (sampleValid) n++;
         tick(1);
      end
      if (afcFastMode === 1'b1) expire("fast end");
      check("fast samples", 8, n);
      diff = freqErrorEstimate - freqOffset;
      check("estimate near offset", 1, diff <= 8 && diff >= -8);
      check("slicer mode", freqErrorEstimate, slicerOffset);
      check("if idle", 0, ifCorrection);
      afcCfg.corrMode = CORR_IF;
      freqOffset = freqOffset + 12'h12c;
      tick(40);
      diff = freqErrorEstimate - freqOffset + 12'h12c;
      check("slow gain hold", 1, diff <= 20 && diff >= -20);
      check("if mode", freqErrorEstimate, ifCorrection);
      check("slicer idle", 0, slicerOffset);
      afcCfg.enable = 1'b0;
      tick(2);
      check("no correction off", 0, ifCorrection);
      $display("test frequency loop done");
      // zero fast period: fast until sync
      afcCfg.fastPeriod = 8'h00;
      fastQ.push_back(1'b1);
      afcCfg.enable = 1'b1;
      drain(20);
      tick(60);
      check("fast before sync", 1, afcFastMode);
      fastQ.push_back(1'b0);
      syncDetected = 1'b1;
      drain(20);
      modIsFreq = 1'b0;
      tick(2);
      check("if after am", 0, ifCorrection);
      $display("test sync switch done");
      results();
   end
endmodule
`default_nettype wire
